// ### core/arc_regs.vh
// arc_regs.vh - constants of the alternator regulation mode control
// assumes a 10 MHz clock; fuse pins are stable once power is up
`ifndef ARC_REGS_VH
`define ARC_REGS_VH

// clock and timing
`define ARC_CLK_HZ          10000000
`define ARC_CYC_PER_MS      (`ARC_CLK_HZ / 1000)
`define ARC_RPM_K           (48'd60 * `ARC_CLK_HZ)
`define ARC_INACT_SHORT_MS  1300
`define ARC_INACT_LONG_MS   3000
`define ARC_INACT_SHORT_CYC (`ARC_INACT_SHORT_MS * `ARC_CYC_PER_MS)
`define ARC_INACT_LONG_CYC  (`ARC_INACT_LONG_MS * `ARC_CYC_PER_MS)
`define ARC_RAMP_A_MS       3000
`define ARC_RAMP_B_MS       6400
`define ARC_RAMP_C_MS       12300
`define ARC_DUTY_FULL       255
`define ARC_RAMP_A_CYC      (`ARC_RAMP_A_MS * `ARC_CYC_PER_MS / `ARC_DUTY_FULL)
`define ARC_RAMP_B_CYC      (`ARC_RAMP_B_MS * `ARC_CYC_PER_MS / `ARC_DUTY_FULL)
`define ARC_RAMP_C_CYC      (`ARC_RAMP_C_MS * `ARC_CYC_PER_MS / `ARC_DUTY_FULL)
`define ARC_PHASE_LOST_MS   40
`define ARC_PHASE_LOST_CYC  (`ARC_PHASE_LOST_MS * `ARC_CYC_PER_MS)

// register offsets (byte addresses)
`define ARC_OFS_STATUS      8'h00
`define ARC_OFS_MASK        8'h04
`define ARC_OFS_STATE       8'h08
`define ARC_OFS_PERIOD      8'h0c
`define ARC_OFS_CONTROL     8'h10

// status and mask bit positions
`define ARC_EV_CHECKSUM     0
`define ARC_EV_NO_RESP      1
`define ARC_EV_SYNC         2
`define ARC_EV_PARITY       3
`define ARC_EV_TIMEOUT      4
`define ARC_EV_REG_START    5
`define ARC_EV_REG_STOP     6
`define ARC_EV_MODE         7
`define ARC_EV_W            8

// state register fields
`define ARC_ST_MODE_LSB     0
`define ARC_ST_REG_BIT      2
`define ARC_ST_BUS_BIT      3
`define ARC_ST_PHASE_BIT    4
`define ARC_ST_TARGET_LSB   8
`define ARC_ST_DUTY_LSB     16

// control register fields and reset values
`define ARC_CTL_ENABLE_BIT  0
`define ARC_CONTROL_RST     1'b1
`define ARC_MASK_RST        8'h00
`define ARC_DEFAULT_V_BASE  8'h87

`endif

// ### core/arc_period_meter.v
// arc_period_meter - measures the stator phase period in clock cycles
// assumes stator_sense_a is a squared, clean phase signal synchronous to clk
`include "arc_regs.vh"

module arc_period_meter #(
   parameter [23:0] LOST_CYC = `ARC_PHASE_LOST_CYC
) (
   // system
   input  wire        clk,
   input  wire        reset,
   // phase input
   input  wire        stator_sense_a,
   // measurement
   output reg  [23:0] period,
   output reg         phase_active
);

   reg        prev_a;
   reg [23:0] count;

   // period taken on each rising edge, activity lost when the count runs out
   always @(posedge clk) begin
      if (reset) begin
         prev_a       <= 1'b0;
         count        <= 24'h000000;
         period       <= 24'h000000;
         phase_active <= 1'b0;
      end else begin
         prev_a <= stator_sense_a;
         if (stator_sense_a & ~prev_a) begin
            period       <= count;
            count        <= 24'h000001;
            phase_active <= (count < LOST_CYC);    // first edge after a stop only arms
         end else if (count >= LOST_CYC) begin
            phase_active <= 1'b0;
         end else begin
            count <= count + 24'h000001;
         end
      end
   end

endmodule

// ### core/arc_duty_ramp.v
// arc_duty_ramp - rise-limited follower of the requested field duty
// assumes step_cyc is steady while limiting; zero means no limit
module arc_duty_ramp (
   // system
   input  wire        clk,
   input  wire        reset,
   // control
   input  wire [7:0]  request,
   input  wire        limit_en,
   input  wire [23:0] step_cyc,
   // output
   output reg  [7:0]  duty
);

   reg [23:0] tick;

   // one duty step per interval upward; downward follows at once
   always @(posedge clk) begin
      if (reset) begin
         duty <= 8'h00;
         tick <= 24'h000000;
      end else if (request <= duty || !limit_en || step_cyc == 24'h000000) begin
         duty <= request;
         tick <= 24'h000000;
      end else if (tick >= step_cyc - 24'h000001) begin
         duty <= duty + 8'h01;
         tick <= 24'h000000;
      end else begin
         tick <= tick + 24'h000001;
      end
   end

endmodule

// ### core/arc_mode_control.v
// arc_mode_control - mode, start/stop and setpoint control of the regulator
// assumes the frame layer outside pulses activity, setpoint and error strobes,
// and an analog front end reports the phase difference against four levels
`include "arc_regs.vh"

module arc_mode_control #(
   parameter [24:0] INACT_SHORT_CYC = `ARC_INACT_SHORT_CYC,
   parameter [24:0] INACT_LONG_CYC  = `ARC_INACT_LONG_CYC,
   parameter [23:0] RAMP_A_CYC      = `ARC_RAMP_A_CYC,
   parameter [23:0] RAMP_B_CYC      = `ARC_RAMP_B_CYC,
   parameter [23:0] RAMP_C_CYC      = `ARC_RAMP_C_CYC,
   parameter [23:0] PHASE_LOST_CYC  = `ARC_PHASE_LOST_CYC
) (
   // system
   input  wire        clk,
   input  wire        reset,
   // ahb-lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   // fuse options
   input  wire        self_start_fuse,
   input  wire        self_start_thresh_fuse,
   input  wire [1:0]  phase_sens_fuse,
   input  wire [3:0]  default_volt_fuse,
   input  wire [2:0]  start_speed_fuse,
   input  wire [1:0]  stop_speed_fuse,
   input  wire [1:0]  ramp_rate_fuse,
   input  wire [1:0]  ramp_disable_fuse,
   input  wire        inactivity_fuse,
   input  wire        pole_pair_fuse,
   // serial bus frame layer
   input  wire        bus_activity,
   input  wire        setpoint_write,
   input  wire [7:0]  setpoint_volt,
   input  wire        checksum_err,
   input  wire        no_response_err,
   input  wire        sync_break_err,
   input  wire        parity_err,
   input  wire        report_sent,
   output reg         bus_timeout_flag,
   output reg         com_error_flag,
   // stator sensing
   input  wire        stator_sense_a,
   input  wire [3:0]  stator_diff_over,
   // regulator
   input  wire [7:0]  duty_request,
   output wire [7:0]  field_drive_output,
   output reg  [7:0]  target_voltage,
   output reg  [1:0]  op_mode,
   output reg         regulating,
   output reg         bus_ok,
   output reg         irq
);

   localparam [1:0] MODE_STANDBY = 2'b00;
   localparam [1:0] MODE_PRE_EXC = 2'b01;
   localparam [1:0] MODE_DEFAULT = 2'b10;
   localparam [1:0] MODE_NORMAL  = 2'b11;

   // speed scaled by phase period: period*pairs*rpm against 60*f_clk
   function [47:0] speed_prod;
      input [23:0] per;
      input [3:0]  pairs;
      input [12:0] rpm;
      begin
         speed_prod = {24'h000000, per} * {44'h0, pairs} * {35'h0, rpm};
      end
   endfunction

   // captured fuse configuration
   reg        cfg_loaded;
   reg        cfg_self_start;
   reg [12:0] cfg_self_rpm;
   reg [1:0]  cfg_sens;
   reg [7:0]  cfg_default_v;
   reg [12:0] cfg_start_rpm;
   reg [12:0] cfg_stop_rpm;
   reg [23:0] cfg_ramp_step;
   reg [12:0] cfg_dis_rpm;
   reg [24:0] cfg_inact;
   reg [3:0]  cfg_pairs;

   // bus and mode state
   reg [24:0] inact_cnt;
   reg        timeout_evt;
   reg [7:0]  setpoint;
   reg [1:0]  next_mode;
   reg        next_reg;
   reg [7:0]  next_target;

   // register file
   reg [`ARC_EV_W-1:0] status;
   reg [`ARC_EV_W-1:0] mask;
   reg                 ctl_enable;
   reg                 wr_pend;
   reg [7:0]           wr_addr;
   reg [31:0]          rd_word;
   reg [`ARC_EV_W-1:0] events;
   reg [`ARC_EV_W-1:0] next_status;

   wire [23:0] period;
   wire        phase_active;
   wire [47:0] prod_start;
   wire [47:0] prod_stop;
   wire [47:0] prod_dis;
   wire [12:0] start_rpm;
   wire        diff_ok;
   wire        ramp_en;
   wire [7:0]  ramp_req;
   wire        take;
   wire        any_activity;

   arc_period_meter #(
      .LOST_CYC (PHASE_LOST_CYC)
   ) u_meter (
      .clk            (clk),
      .reset          (reset),
      .stator_sense_a (stator_sense_a),
      .period         (period),
      .phase_active   (phase_active)
   );

   // fuses sampled once, on the first clock after reset release
   always @(posedge clk) begin
      if (reset) begin
         cfg_loaded     <= 1'b0;
         cfg_self_start <= 1'b0;
         cfg_self_rpm   <= 13'd3000;
         cfg_sens       <= 2'b00;
         cfg_default_v  <= `ARC_DEFAULT_V_BASE;
         cfg_start_rpm  <= 13'd800;
         cfg_stop_rpm   <= 13'd500;
         cfg_ramp_step  <= 24'h000000;
         cfg_dis_rpm    <= 13'd2400;
         cfg_inact      <= INACT_SHORT_CYC;
         cfg_pairs      <= 4'd6;
      end else if (!cfg_loaded) begin
         cfg_loaded     <= 1'b1;
         cfg_self_start <= self_start_fuse;
         cfg_self_rpm   <= self_start_thresh_fuse ? 13'd4000 : 13'd3000;
         cfg_sens       <= phase_sens_fuse;
         cfg_default_v  <= `ARC_DEFAULT_V_BASE + {4'h0, default_volt_fuse};
         cfg_inact      <= inactivity_fuse ? INACT_LONG_CYC : INACT_SHORT_CYC;
         cfg_pairs      <= pole_pair_fuse ? 4'd8 : 4'd6;
         case (start_speed_fuse)
            3'd0: cfg_start_rpm <= 13'd800;
            3'd1: cfg_start_rpm <= 13'd1050;
            3'd2: cfg_start_rpm <= 13'd1300;
            3'd3: cfg_start_rpm <= 13'd1550;
            3'd4: cfg_start_rpm <= 13'd1800;
            3'd5: cfg_start_rpm <= 13'd2050;
            3'd6: cfg_start_rpm <= 13'd2300;
            default: cfg_start_rpm <= 13'd2500;
         endcase
         case (stop_speed_fuse)
            2'd0: cfg_stop_rpm <= 13'd500;
            2'd1: cfg_stop_rpm <= 13'd650;
            2'd2: cfg_stop_rpm <= 13'd850;
            default: cfg_stop_rpm <= 13'd1000;
         endcase
         case (ramp_rate_fuse)
            2'd0: cfg_ramp_step <= 24'h000000;
            2'd1: cfg_ramp_step <= RAMP_A_CYC;
            2'd2: cfg_ramp_step <= RAMP_B_CYC;
            default: cfg_ramp_step <= RAMP_C_CYC;
         endcase
         case (ramp_disable_fuse)
            2'd0: cfg_dis_rpm <= 13'd2400;
            2'd1: cfg_dis_rpm <= 13'd3000;
            2'd2: cfg_dis_rpm <= 13'd4000;
            default: cfg_dis_rpm <= 13'd0;          // never disabled
         endcase
      end
   end

   // speed comparisons; a zero period means no measurement yet
   assign start_rpm  = bus_ok ? cfg_start_rpm : cfg_self_rpm;
   assign prod_start = speed_prod(period, cfg_pairs, start_rpm);
   assign prod_stop  = speed_prod(period, cfg_pairs, cfg_stop_rpm);
   assign prod_dis   = speed_prod(period, cfg_pairs, cfg_dis_rpm);
   assign diff_ok    = stator_diff_over[cfg_sens];
   assign any_activity = bus_activity | setpoint_write;

   // bus inactivity watchdog; traffic restores the bus at once
   always @(posedge clk) begin
      if (reset) begin
         inact_cnt   <= 25'h0000000;
         bus_ok      <= 1'b0;
         timeout_evt <= 1'b0;
      end else begin
         timeout_evt <= 1'b0;
         if (any_activity) begin
            inact_cnt <= 25'h0000000;
            bus_ok    <= 1'b1;
         end else if (inact_cnt >= cfg_inact - 25'h0000001) begin
            bus_ok      <= 1'b0;
            timeout_evt <= bus_ok;
         end else begin
            inact_cnt <= inact_cnt + 25'h0000001;
         end
      end
   end

   // latest master setpoint, seeded with the default until one arrives
   always @(posedge clk) begin
      if (reset) begin
         setpoint <= `ARC_DEFAULT_V_BASE;
      end else if (setpoint_write) begin
         setpoint <= setpoint_volt;
      end else if (!cfg_loaded) begin
         setpoint <= `ARC_DEFAULT_V_BASE + {4'h0, default_volt_fuse};
      end
   end

   // mode selection from bus validity and phase activity
   always @* begin
      if (bus_ok || any_activity) begin
         next_mode = phase_active ? MODE_NORMAL : MODE_PRE_EXC;
      end else begin
         next_mode = phase_active ? MODE_DEFAULT : MODE_STANDBY;
      end
   end

   // start and stop of regulation
   always @* begin
      next_reg = regulating;
      if (!cfg_loaded || !ctl_enable || !phase_active) begin
         next_reg = 1'b0;
      end else if (next_mode != MODE_NORMAL && next_mode != MODE_DEFAULT) begin
         next_reg = 1'b0;
      end else if (next_mode == MODE_DEFAULT && !regulating && !cfg_self_start) begin
         next_reg = 1'b0;
      end else if (!regulating) begin
         next_reg = diff_ok && period != 24'h000000 && prod_start <= `ARC_RPM_K;
      end else if (prod_stop >= `ARC_RPM_K) begin
         next_reg = 1'b0;
      end
   end

   // target voltage: master value in normal mode, fused default otherwise
   always @* begin
      if (next_mode == MODE_NORMAL) begin
         next_target = setpoint_write ? setpoint_volt : setpoint;
      end else begin
         next_target = cfg_default_v;
      end
   end

   always @(posedge clk) begin
      if (reset) begin
         op_mode        <= MODE_STANDBY;
         regulating     <= 1'b0;
         target_voltage <= `ARC_DEFAULT_V_BASE;
      end else begin
         op_mode        <= next_mode;
         regulating     <= next_reg;
         target_voltage <= next_target;
      end
   end

   // ramp limited below the disable speed; rate zero means instant
   assign ramp_en  = cfg_dis_rpm == 13'd0 || prod_dis > `ARC_RPM_K;
   assign ramp_req = regulating ? duty_request : 8'h00;

   arc_duty_ramp u_ramp (
      .clk      (clk),
      .reset    (reset),
      .request  (ramp_req),
      .limit_en (ramp_en),
      .step_cyc (cfg_ramp_step),
      .duty     (field_drive_output)
   );

   // error flags for the frame layer to report; a new error beats the clear
   always @(posedge clk) begin
      if (reset) begin
         bus_timeout_flag <= 1'b0;
         com_error_flag   <= 1'b0;
      end else begin
         bus_timeout_flag <= timeout_evt | (bus_timeout_flag & ~report_sent);
         com_error_flag   <= checksum_err | no_response_err | sync_break_err |
                             parity_err | (com_error_flag & ~report_sent);
      end
   end

   // event collection for the status register
   always @* begin
      events = {`ARC_EV_W{1'b0}};
      events[`ARC_EV_CHECKSUM]  = checksum_err;
      events[`ARC_EV_NO_RESP]   = no_response_err;
      events[`ARC_EV_SYNC]      = sync_break_err;
      events[`ARC_EV_PARITY]    = parity_err;
      events[`ARC_EV_TIMEOUT]   = timeout_evt;
      events[`ARC_EV_REG_START] = next_reg & ~regulating;
      events[`ARC_EV_REG_STOP]  = ~next_reg & regulating;
      events[`ARC_EV_MODE]      = next_mode != op_mode;
   end

   // bus slave: zero wait states, read data registered in the address phase
   assign take = hsel & htrans[1] & hready;

   always @* begin
      rd_word = 32'h00000000;
      case (haddr[7:0])
         `ARC_OFS_STATUS: rd_word[`ARC_EV_W-1:0] = status;
         `ARC_OFS_MASK:   rd_word[`ARC_EV_W-1:0] = mask;
         `ARC_OFS_STATE: begin
            rd_word[`ARC_ST_MODE_LSB+1:`ARC_ST_MODE_LSB]     = op_mode;
            rd_word[`ARC_ST_REG_BIT]                         = regulating;
            rd_word[`ARC_ST_BUS_BIT]                         = bus_ok;
            rd_word[`ARC_ST_PHASE_BIT]                       = phase_active;
            rd_word[`ARC_ST_TARGET_LSB+7:`ARC_ST_TARGET_LSB] = target_voltage;
            rd_word[`ARC_ST_DUTY_LSB+7:`ARC_ST_DUTY_LSB]     = field_drive_output;
         end
         `ARC_OFS_PERIOD:  rd_word[23:0] = period;
         `ARC_OFS_CONTROL: rd_word[`ARC_CTL_ENABLE_BIT] = ctl_enable;
         default: rd_word = 32'h00000000;           // unmapped reads as zero
      endcase
   end

   // read of status clears it; events of the same cycle survive
   always @* begin
      next_status = status;
      if (take && !hwrite && haddr[7:0] == `ARC_OFS_STATUS) begin
         next_status = {`ARC_EV_W{1'b0}};
      end
      next_status = next_status | events;
   end

   always @(posedge clk) begin
      if (reset) begin
         hrdata     <= 32'h00000000;
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
         wr_pend    <= 1'b0;
         wr_addr    <= 8'h00;
         status     <= {`ARC_EV_W{1'b0}};
         mask       <= `ARC_MASK_RST;
         ctl_enable <= `ARC_CONTROL_RST;
         irq        <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wr_pend   <= take & hwrite;
         wr_addr   <= haddr[7:0];
         if (take && !hwrite) begin
            hrdata <= rd_word;
         end
         status <= next_status;
         irq    <= |(next_status & mask);
         if (wr_pend && wr_addr == `ARC_OFS_MASK) begin
            mask <= hwdata[`ARC_EV_W-1:0];
         end
         if (wr_pend && wr_addr == `ARC_OFS_CONTROL) begin
            ctl_enable <= hwdata[`ARC_CTL_ENABLE_BIT];
         end
      end
   end

endmodule

// ### bench/arc_chk_asserts.sv
// arc_chk: port checks of the regulator mode control
// assumes bind to arc_mode_control, fuse inputs steady after reset
module arc_chk #(
   parameter [24:0] INACT_SHORT_CYC = 25'hc8,
   parameter [24:0] INACT_LONG_CYC  = 25'h190
) (
   // system
   input logic       clk,
   input logic       reset,
   // strobes and fuses
   input logic       bus_activity,
   input logic       setpoint_write,
   input logic [7:0] setpoint_volt,
   input logic       checksum_err,
   input logic       no_response_err,
   input logic       sync_break_err,
   input logic       parity_err,
   input logic       report_sent,
   input logic       inactivity_fuse,
   input logic [3:0] default_volt_fuse,
   input logic [1:0] ramp_rate_fuse,
   input logic [1:0] ramp_disable_fuse,
   input logic [7:0] duty_request,
   // outputs
   input logic       com_error_flag,
   input logic       bus_ok,
   input logic [7:0] target_voltage,
   input logic [1:0] op_mode,
   input logic       regulating,
   input logic [7:0] field_drive_output
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   logic [24:0] idle_cnt;
   wire         err_any = checksum_err | no_response_err | sync_break_err | parity_err;
   wire  [24:0] idle_lim = inactivity_fuse ? INACT_LONG_CYC : INACT_SHORT_CYC;
   wire         ramp_on = ramp_rate_fuse != 2'h0 && ramp_disable_fuse == 2'h3;
   // cycles since the master last showed traffic, saturating
   always @(posedge clk)
      if (reset || bus_activity || setpoint_write) idle_cnt <= 25'h0;
      else if (idle_cnt != 25'h1ffffff) idle_cnt <= idle_cnt + 25'h1;
   sequence s_write; setpoint_write; endsequence
   sequence s_dflt; op_mode == 2'h2 ##1 op_mode == 2'h2; endsequence
   sequence s_low; op_mode < 2'h2 ##1 op_mode < 2'h2; endsequence
   property p_err_set; err_any |=> com_error_flag; endproperty
   property p_err_clr; report_sent && !err_any |=> !com_error_flag; endproperty
   property p_bus_up; bus_activity || setpoint_write |=> bus_ok; endproperty
   property p_setpoint;
      s_write |=> op_mode != 2'h3 || target_voltage == $past(setpoint_volt);
   endproperty
   property p_takeover; op_mode == 2'h2 ##0 s_write |=> op_mode == 2'h3; endproperty
   property p_idle; idle_cnt > idle_lim + 25'h2 |-> !bus_ok; endproperty
   property p_dflt_v; s_dflt |-> target_voltage == 8'h87 + {4'h0, default_volt_fuse};
   endproperty
   property p_standby; s_low |-> !regulating; endproperty
   property p_fall;
      duty_request < field_drive_output |-> ##[1:2] field_drive_output <= duty_request;
   endproperty
   // a rise larger than one step means the limiter was bypassed
   property p_rise;
      ramp_on && field_drive_output > $past(field_drive_output)
         |-> field_drive_output == $past(field_drive_output) + 8'h01;
   endproperty
   a_err_set: assert property (p_err_set) else $error("error not flagged");
   a_err_clr: assert property (p_err_clr) else $error("error flag stuck");
   a_bus_up: assert property (p_bus_up) else $error("bus_ok not set");
   a_setpoint: assert property (p_setpoint) else $error("setpoint not used");
   a_takeover: assert property (p_takeover) else $error("bus not priority");
   a_idle: assert property (p_idle) else $error("idle time-out missed");
   a_dflt_v: assert property (p_dflt_v) else $error("wrong default target");
   a_standby: assert property (p_standby) else $error("regulating in standby");
   a_fall: assert property (p_fall) else $error("duty decrease delayed");
   a_rise: assert property (p_rise) else $error("duty rise too fast");
endmodule
bind arc_mode_control arc_chk #(
   .INACT_SHORT_CYC(INACT_SHORT_CYC), .INACT_LONG_CYC(INACT_LONG_CYC)
) u_chk (
   .clk(clk), .reset(reset), .bus_activity(bus_activity), .setpoint_write(setpoint_write),
   .setpoint_volt(setpoint_volt), .checksum_err(checksum_err),
   .no_response_err(no_response_err), .sync_break_err(sync_break_err),
   .parity_err(parity_err), .report_sent(report_sent), .inactivity_fuse(inactivity_fuse),
   .default_volt_fuse(default_volt_fuse), .ramp_rate_fuse(ramp_rate_fuse),
   .ramp_disable_fuse(ramp_disable_fuse), .duty_request(duty_request),
   .com_error_flag(com_error_flag), .bus_ok(bus_ok), .target_voltage(target_voltage),
   .op_mode(op_mode), .regulating(regulating), .field_drive_output(field_drive_output)
);

// ### bench/arc_ecu_model.sv
// arc_ecu_model: frame-layer strobes as the engine unit causes them
// assumes its tasks are called just after a rising edge of clk
module arc_ecu_model (
   // system
   input  logic       clk,
   // frame layer strobes
   output logic       bus_activity,
   output logic       setpoint_write,
   output logic [7:0] setpoint_volt,
   output logic [3:0] err,
   output logic       report_sent
);
   timeunit 1ns;
   timeprecision 1ns;
   // quiet bus at time zero
   initial begin
      bus_activity = 1'b0;
      setpoint_write = 1'b0;
      setpoint_volt = 8'h55;
      err = 4'h0;
      report_sent = 1'b0;
   end
   // setpoint write frame; data goes stale after it, not left valid
   task automatic send_setpoint(input logic [7:0] v);
      bus_activity <= 1'b1;
      setpoint_write <= 1'b1;
      setpoint_volt <= v;
      @(posedge clk);
      bus_activity <= 1'b0;
      setpoint_write <= 1'b0;
      setpoint_volt <= ~v;
   endtask
   // a failed frame (e) or a status read-out frame (rep)
   task automatic send_frame(input logic [3:0] e, input logic rep);
      bus_activity <= 1'b1;
      err <= e;
      report_sent <= rep;
      @(posedge clk);
      bus_activity <= 1'b0;
      err <= 4'h0;
      report_sent <= 1'b0;
   endtask
endmodule

// ### bench/tb_top.sv
// tb_top: self-checking bench of the regulator mode control
// assumes shortened time-outs and ramp steps set at the instance
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, reset, hsel, hwrite, stator_sense_a, phase_run;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans, op_mode;
   logic [14:0] fz;
   logic [3:0]  err;
   logic [7:0]  duty_request, target_voltage, field_drive_output, sp, setpoint_volt;
   logic        hreadyout, hresp, bus_activity, setpoint_write, report_sent;
   logic        bus_timeout_flag, com_error_flag, regulating, bus_ok, irq;
   logic [6:0]  ph_cnt;
   int          fail_count, tests_run, n;
   wire         hready;
   assign hready = hreadyout;
   initial clk = 1'b0;
   always #50 clk = ~clk;
   // phase square wave of 100 cycles, well inside the phase-loss limit
   always @(posedge clk) begin
      ph_cnt <= (ph_cnt == 7'h31) ? 7'h0 : ph_cnt + 7'h1;
      if (phase_run && ph_cnt == 7'h31) stator_sense_a <= ~stator_sense_a;
   end
   arc_mode_control #(
      .INACT_SHORT_CYC(25'hc8), .INACT_LONG_CYC(25'h190), .RAMP_A_CYC(24'h4),
      .RAMP_B_CYC(24'h8), .RAMP_C_CYC(24'h10), .PHASE_LOST_CYC(24'h7d0)
   ) u_dut (
      .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .self_start_fuse(fz[14]),
      .self_start_thresh_fuse(fz[0]), .phase_sens_fuse(fz[2:1]),
      .default_volt_fuse(fz[13:10]), .start_speed_fuse(fz[5:3]), .stop_speed_fuse(fz[7:6]),
      .ramp_rate_fuse(2'h1), .ramp_disable_fuse(2'h3), .inactivity_fuse(fz[8]),
      .pole_pair_fuse(fz[9]), .bus_activity(bus_activity), .setpoint_write(setpoint_write),
      .setpoint_volt(setpoint_volt), .checksum_err(err[0]), .no_response_err(err[1]),
      .sync_break_err(err[2]), .parity_err(err[3]), .report_sent(report_sent),
      .bus_timeout_flag(bus_timeout_flag), .com_error_flag(com_error_flag),
      .stator_sense_a(stator_sense_a), .stator_diff_over({4{phase_run}}),
      .duty_request(duty_request),
      .field_drive_output(field_drive_output), .target_voltage(target_voltage),
      .op_mode(op_mode), .regulating(regulating), .bus_ok(bus_ok), .irq(irq)
   );
   arc_ecu_model u_ecu (
      .clk(clk), .bus_activity(bus_activity), .setpoint_write(setpoint_write),
      .setpoint_volt(setpoint_volt), .err(err), .report_sent(report_sent)
   );
   task automatic finish_test;
      if (fail_count == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic hang;
      fail_count++;
      finish_test();
   endtask
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("mismatch at %0t: expected %h got %h", $time, exp, got);
         fail_count++;
      end
   endtask
   // next edge with hready high; a stuck bus ends the run
   task automatic rdy;
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (hready !== 1'b1 && k < 20);
      if (k >= 20) hang();
   endtask
   // single word transfer; read data lands in rd at the data-phase edge
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      rdy();
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
      rd = hrdata;
   endtask
   // guard against a hang anywhere
   initial begin
      repeat (100000) @(posedge clk);
      hang();
   end
   initial begin
      void'($urandom(80930));
      fz = 15'($urandom);
      reset = 1'b1;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      {duty_request, stator_sense_a, phase_run, ph_cnt} = '0;
      fail_count = 0;
      tests_run = 0;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      chk(32'h87, 32'(target_voltage));
      chk(32'h0, 32'(op_mode));
      ahb(1'b0, 32'h10, 32'h0);
      chk(32'h1, rd);
      ahb(1'b0, 32'h04, 32'h0);
      chk(32'h0, rd);
      ahb(1'b0, 32'h20, 32'h0);
      chk(32'h0, rd);
      ahb(1'b1, 32'h04, 32'hff);
      ahb(1'b0, 32'h04, 32'h0);
      chk(32'hff, rd);
      // no bus since reset: self-start with fused defaults once phases run
      phase_run <= 1'b1;
      for (n = 0; n < 3000 && regulating !== 1'b1; n++) @(posedge clk);
      chk(32'h2, 32'(op_mode));
      chk(32'(fz[14]), 32'(regulating));
      chk(32'h87 + 32'(fz[13:10]), 32'(target_voltage));
      for (n = 0; n < 4; n++) begin
         sp = 8'h6a + 8'($urandom % 55);
         u_ecu.send_setpoint(sp);
         @(posedge clk);
         chk(32'h3, 32'(op_mode));
         chk(32'(sp), 32'(target_voltage));
      end
      duty_request <= 8'h14;
      for (n = 0; n < 300 && field_drive_output !== 8'h14; n++) @(posedge clk);
      chk(32'h1, 32'(n >= 76 && n <= 84));
      duty_request <= 8'h03;
      repeat (3) @(posedge clk);
      chk(32'h3, 32'(field_drive_output));
      for (n = 0; n < 4; n++) begin
         u_ecu.send_frame(4'h1 << n, 1'b0);
         repeat (2) @(posedge clk);
         chk(32'h1, 32'(com_error_flag & irq));
         ahb(1'b0, 32'h0, 32'h0);
         chk(32'h1, 32'(rd[n]));
         u_ecu.send_frame(4'h0, 1'b1);
         @(posedge clk);
         chk(32'h0, 32'(com_error_flag | irq));
      end
      // silence the master until the idle time-out hits
      for (n = 0; n < 3000 && bus_ok !== 1'b0; n++) @(posedge clk);
      chk(fz[8] ? 400 : 200, n);
      @(posedge clk);
      chk(32'h1, 32'(bus_timeout_flag));
      chk(32'h2, 32'(op_mode));
      chk(32'h87 + 32'(fz[13:10]), 32'(target_voltage));
      phase_run <= 1'b0;
      for (n = 0; n < 5000 && op_mode !== 2'h0; n++) @(posedge clk);
      chk(32'h0, 32'(op_mode));
      chk(32'h0, 32'(regulating));
      finish_test();
   end
endmodule
